//--- hdl/drive_flag_pkg.sv
`default_nettype none
package drive_flag_pkg;

   // -------------------------------------------------------------
   // register map (byte addresses, one word each)
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LL_LEVEL = 8'h04;
   localparam logic [7:0] OFS_OL_LEVEL = 8'h08;
   localparam logic [7:0] OFS_OL_LEVEL2 = 8'h0c;
   localparam logic [7:0] OFS_ACC_THR = 8'h10;
   localparam logic [7:0] OFS_DEC_THR = 8'h14;
   localparam logic [7:0] OFS_PID_DEV = 8'h18;
   localparam logic [7:0] OFS_PV_HIGH = 8'h1c;
   localparam logic [7:0] OFS_PV_LOW = 8'h20;
   localparam logic [7:0] OFS_WDOG = 8'h24;
   localparam logic [7:0] OFS_OPT_TO = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2c;
   localparam logic [7:0] OFS_MONITOR = 8'h30;

   // -------------------------------------------------------------
   // control word fields
   // -------------------------------------------------------------
   localparam int SEL_W = 6;
   localparam int CTRL_TERM0_LSB = 0;
   localparam int CTRL_TERM1_LSB = 8;
   localparam int CTRL_AM_SEL_BIT = 16;
   localparam int CTRL_LL_MODE_BIT = 17;
   localparam int CTRL_MOTOR2_BIT = 18;
   localparam int N_TERM = 2;

   // -------------------------------------------------------------
   // ranges and defaults (current and percent in 0.1 % units, freq 0.1 Hz)
   // -------------------------------------------------------------
   localparam logic [15:0] RATED_CURRENT = 16'h03e8;
   localparam logic [15:0] CURRENT_MAX = 16'h07d0;
   localparam logic [15:0] FREQ_MAX = 16'h0fa0;
   localparam logic [15:0] PCT_MAX = 16'h03e8;
   localparam logic [15:0] PID_DEV_DEF = 16'h001e;
   localparam logic [15:0] PV_HIGH_DEF = 16'h03e8;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [15:0] WDOG_MAX = 16'h270f;
   localparam logic [15:0] OPT_TO_DEF = 16'h0064;

   // -------------------------------------------------------------
   // output function codes and modes
   // -------------------------------------------------------------
   localparam logic [SEL_W-1:0] FN_RUN = 6'h00;
   localparam logic [SEL_W-1:0] FN_CONST_ARRIVAL = 6'h01;
   localparam logic [SEL_W-1:0] FN_OVER_ARRIVAL = 6'h02;
   localparam logic [SEL_W-1:0] FN_OVERLOAD = 6'h03;
   localparam logic [SEL_W-1:0] FN_PID_EXCESS = 6'h04;
   localparam logic [SEL_W-1:0] FN_PID_SECOND = 6'h07;
   localparam logic [SEL_W-1:0] FN_NET_TIMEOUT = 6'h08;
   localparam logic [SEL_W-1:0] FN_LOGIC = 6'h09;
   localparam logic [SEL_W-1:0] FN_OPT_FAULT = 6'h0a;
   localparam logic [SEL_W-1:0] FN_LOW_LOAD = 6'h2b;
   localparam logic AM_SRC_FREQ = 1'b0;
   localparam logic AM_SRC_CURRENT = 1'b1;
   localparam logic LL_MODE_ALL = 1'b0;
   localparam logic LL_MODE_CONST = 1'b1;

   // -------------------------------------------------------------
   // timing and monitor scale
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int TIMEOUT_TICK_NS = 10_000_000;
   localparam int TICK_CYCLES_DEF = TIMEOUT_TICK_NS / CLK_PERIOD_NS;
   localparam int AM_W = 10;
   localparam logic [AM_W-1:0] AM_FULL = 10'h3ff;

   typedef struct packed {
      logic run;
      logic const_arrival;
      logic over_arrival;
      logic overload_warning;
      logic pid_error_excess;
      logic pid_second_stage;
      logic network_timeout;
      logic logic_out;
      logic option_link_fault;
      logic low_load;
   } flags_type;

   typedef struct packed {
      logic [N_TERM-1:0][SEL_W-1:0] term_sel;
      logic analog_monitor_source_select;
      logic low_load_mode;
      logic second_motor;
      logic [15:0] low_load_level;
      logic [15:0] overload_level;
      logic [15:0] overload_level_second_motor;
      logic [15:0] accel_arrival_threshold;
      logic [15:0] decel_arrival_threshold;
      logic [15:0] pid_deviation_threshold;
      logic [15:0] pv_high_limit;
      logic [15:0] pv_low_limit;
      logic [15:0] comm_watchdog_period;
      logic [15:0] option_link_timeout;
   } cfg_type;

endpackage
`default_nettype wire

//--- hdl/drive_status_flag_generator.sv
`timescale 1ns/1ps
`default_nettype none
module drive_status_flag_generator
   import drive_flag_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF,
   parameter logic [15:0] OPT_TIMEOUT_DEFAULT = OPT_TO_DEF,
   parameter logic [15:0] MAX_FREQ = FREQ_MAX
) (
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [15:0] OUTPUT_FREQ,
   input wire logic [15:0] SET_FREQ,
   input wire logic [15:0] MOTOR_CURRENT,
   input wire logic [15:0] PID_SETPOINT,
   input wire logic [15:0] PID_PV,
   input wire logic RUNNING,
   input wire logic ACCELERATING,
   input wire logic DECELERATING,
   input wire logic COMM_ACTIVITY,
   input wire logic OPTION_ACTIVITY,
   input wire logic LOGIC_RESULT,
   output logic [N_TERM-1:0] OUT_TERM,
   output flags_type FLAGS,
   output logic [AM_W-1:0] ANALOG_MONITOR
);

   // -------------------------------------------------------------
   // parameter checks
   // -------------------------------------------------------------
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYCLES - 1);

   if (TICK_CYCLES < 1) begin : bad_tick
      $error("TICK_CYCLES must be at least one");
   end
   if (MAX_FREQ == ZERO16 || MAX_FREQ > FREQ_MAX) begin : bad_freq
      $error("MAX_FREQ out of range");
   end
   if (OPT_TIMEOUT_DEFAULT > WDOG_MAX) begin : bad_opt
      $error("OPT_TIMEOUT_DEFAULT out of range");
   end

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef struct packed {
      cfg_type cfg;
      flags_type flags;
      logic [N_TERM-1:0] term;
      logic [AM_W-1:0] monitor;
      logic run_d;
      logic [CW-1:0] tick_cnt;
      logic [15:0] wdog_cnt;
      logic [15:0] opt_cnt;
      logic [31:0] prdata;
      logic pslverr;
   } state_type;

   state_type state_r;
   state_type state_nxt;

   function automatic logic [15:0] clamp(input logic [31:0] v, input logic [15:0] mx);
      clamp = (v > {16'h0000, mx}) ? mx : v[15:0];
   endfunction

   function automatic logic readable(input logic [7:0] a);
      readable = (a <= OFS_MONITOR) && (a[1:0] == 2'b00);
   endfunction

   // -------------------------------------------------------------
   // combinational datapath
   // -------------------------------------------------------------
   logic const_speed;
   logic tick;
   logic [15:0] pid_err;
   logic [15:0] ol_thr;
   logic [15:0] arr_thr;
   logic ll_eval;
   logic [25:0] am_freq;
   logic [26:0] am_cur;
   logic [N_TERM-1:0] term_pick;
   flags_type f;

   assign const_speed = RUNNING && !ACCELERATING && !DECELERATING;
   assign tick = (state_r.tick_cnt == TICK_LAST);
   // error magnitude, either sign of the difference
   assign pid_err = (PID_SETPOINT >= PID_PV) ? PID_SETPOINT - PID_PV
                                             : PID_PV - PID_SETPOINT;
   assign ol_thr = state_r.cfg.second_motor ? state_r.cfg.overload_level_second_motor
                                            : state_r.cfg.overload_level;
   // zero threshold means arrival tracks the set frequency itself
   assign arr_thr = (ACCELERATING && state_r.cfg.accel_arrival_threshold != ZERO16) ?
                    state_r.cfg.accel_arrival_threshold :
                    (DECELERATING && state_r.cfg.decel_arrival_threshold != ZERO16) ?
                    state_r.cfg.decel_arrival_threshold : SET_FREQ;
   assign ll_eval = (state_r.cfg.low_load_mode == LL_MODE_CONST) ? const_speed
                                                                 : RUNNING;
   // constant divisors only, so the dividers fold into multipliers
   assign am_freq = 26'(OUTPUT_FREQ * AM_FULL) / 26'(MAX_FREQ);
   assign am_cur = 27'(MOTOR_CURRENT * AM_FULL) / 27'(CURRENT_MAX);

   always_comb begin
      f = state_r.flags;
      f.run = RUNNING;
      f.const_arrival = const_speed && (OUTPUT_FREQ == SET_FREQ);
      f.over_arrival = RUNNING && (OUTPUT_FREQ >= arr_thr);
      // advisory only: nothing here feeds a trip or a current limit
      f.overload_warning = (MOTOR_CURRENT > ol_thr);
      f.pid_error_excess = (pid_err > state_r.cfg.pid_deviation_threshold);
      if (state_r.run_d && !RUNNING) begin
         f.pid_second_stage = 1'b0;
      end else if (PID_PV > state_r.cfg.pv_high_limit) begin
         f.pid_second_stage = 1'b0;
      end else if (RUNNING && PID_PV < state_r.cfg.pv_low_limit) begin
         f.pid_second_stage = 1'b1;
      end
      // zero period disables the watchdog
      f.network_timeout = (state_r.cfg.comm_watchdog_period != ZERO16) &&
                          !COMM_ACTIVITY &&
                          (state_r.wdog_cnt >= state_r.cfg.comm_watchdog_period);
      f.logic_out = LOGIC_RESULT;
      f.option_link_fault = (state_r.cfg.option_link_timeout != ZERO16) &&
                            !OPTION_ACTIVITY &&
                            (state_r.opt_cnt >= state_r.cfg.option_link_timeout);
      f.low_load = ll_eval && (MOTOR_CURRENT < state_r.cfg.low_load_level);
   end

   // -------------------------------------------------------------
   // per-terminal function select
   // -------------------------------------------------------------
   for (genvar t = 0; t < N_TERM; t++) begin : g_term
      always_comb begin
         case (state_r.cfg.term_sel[t])
            FN_RUN: term_pick[t] = f.run;
            FN_CONST_ARRIVAL: term_pick[t] = f.const_arrival;
            FN_OVER_ARRIVAL: term_pick[t] = f.over_arrival;
            FN_OVERLOAD: term_pick[t] = f.overload_warning;
            FN_PID_EXCESS: term_pick[t] = f.pid_error_excess;
            FN_PID_SECOND: term_pick[t] = f.pid_second_stage;
            FN_NET_TIMEOUT: term_pick[t] = f.network_timeout;
            FN_LOGIC: term_pick[t] = f.logic_out;
            FN_OPT_FAULT: term_pick[t] = f.option_link_fault;
            FN_LOW_LOAD: term_pick[t] = f.low_load;
            default: term_pick[t] = 1'b0;
         endcase
      end
   end

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      state_nxt.flags = f;
      state_nxt.term = term_pick;
      state_nxt.run_d = RUNNING;
      state_nxt.tick_cnt = tick ? '0 : state_r.tick_cnt + 1'b1;
      if (state_r.cfg.analog_monitor_source_select == AM_SRC_CURRENT) begin
         state_nxt.monitor = (am_cur > 27'(AM_FULL)) ? AM_FULL : am_cur[AM_W-1:0];
      end else begin
         state_nxt.monitor = (am_freq > 26'(AM_FULL)) ? AM_FULL : am_freq[AM_W-1:0];
      end
      // traffic restarts the count; saturate so it never wraps back
      if (COMM_ACTIVITY) begin
         state_nxt.wdog_cnt = ZERO16;
      end else if (tick && state_r.wdog_cnt != WDOG_MAX) begin
         state_nxt.wdog_cnt = state_r.wdog_cnt + 1'b1;
      end
      if (OPTION_ACTIVITY) begin
         state_nxt.opt_cnt = ZERO16;
      end else if (tick && state_r.opt_cnt != WDOG_MAX) begin
         state_nxt.opt_cnt = state_r.opt_cnt + 1'b1;
      end

      // apb setup: capture read data so it is stable through access
      if (PSEL && !PENABLE) begin
         state_nxt.pslverr = !readable(PADDR) ||
                             (PWRITE && (PADDR == OFS_STATUS || PADDR == OFS_MONITOR));
         case (PADDR)
            OFS_CTRL: state_nxt.prdata = {13'h0000,
                                         state_r.cfg.second_motor,
                                         state_r.cfg.low_load_mode,
                                         state_r.cfg.analog_monitor_source_select,
                                         2'b00, state_r.cfg.term_sel[1],
                                         2'b00, state_r.cfg.term_sel[0]};
            OFS_LL_LEVEL: state_nxt.prdata = {16'h0000, state_r.cfg.low_load_level};
            OFS_OL_LEVEL: state_nxt.prdata = {16'h0000, state_r.cfg.overload_level};
            OFS_OL_LEVEL2: state_nxt.prdata =
               {16'h0000, state_r.cfg.overload_level_second_motor};
            OFS_ACC_THR: state_nxt.prdata = {16'h0000, state_r.cfg.accel_arrival_threshold};
            OFS_DEC_THR: state_nxt.prdata = {16'h0000, state_r.cfg.decel_arrival_threshold};
            OFS_PID_DEV: state_nxt.prdata = {16'h0000, state_r.cfg.pid_deviation_threshold};
            OFS_PV_HIGH: state_nxt.prdata = {16'h0000, state_r.cfg.pv_high_limit};
            OFS_PV_LOW: state_nxt.prdata = {16'h0000, state_r.cfg.pv_low_limit};
            OFS_WDOG: state_nxt.prdata = {16'h0000, state_r.cfg.comm_watchdog_period};
            OFS_OPT_TO: state_nxt.prdata = {16'h0000, state_r.cfg.option_link_timeout};
            OFS_STATUS: state_nxt.prdata = {20'h00000, state_r.term, state_r.flags};
            OFS_MONITOR: state_nxt.prdata = {22'h000000, state_r.monitor};
            default: state_nxt.prdata = 32'h00000000;
         endcase
      end

      // apb access: write lands at the completing edge; values clamp to range
      if (PSEL && PENABLE && PWRITE && !state_r.pslverr) begin
         case (PADDR)
            OFS_CTRL: begin
               state_nxt.cfg.term_sel[0] = PWDATA[CTRL_TERM0_LSB +: SEL_W];
               state_nxt.cfg.term_sel[1] = PWDATA[CTRL_TERM1_LSB +: SEL_W];
               state_nxt.cfg.analog_monitor_source_select = PWDATA[CTRL_AM_SEL_BIT];
               state_nxt.cfg.low_load_mode = PWDATA[CTRL_LL_MODE_BIT];
               state_nxt.cfg.second_motor = PWDATA[CTRL_MOTOR2_BIT];
            end
            OFS_LL_LEVEL: state_nxt.cfg.low_load_level = clamp(PWDATA, CURRENT_MAX);
            OFS_OL_LEVEL: state_nxt.cfg.overload_level = clamp(PWDATA, CURRENT_MAX);
            OFS_OL_LEVEL2: state_nxt.cfg.overload_level_second_motor =
               clamp(PWDATA, CURRENT_MAX);
            OFS_ACC_THR: state_nxt.cfg.accel_arrival_threshold =
               clamp(PWDATA, FREQ_MAX);
            OFS_DEC_THR: state_nxt.cfg.decel_arrival_threshold =
               clamp(PWDATA, FREQ_MAX);
            OFS_PID_DEV: state_nxt.cfg.pid_deviation_threshold =
               clamp(PWDATA, PCT_MAX);
            OFS_PV_HIGH: state_nxt.cfg.pv_high_limit = clamp(PWDATA, PCT_MAX);
            OFS_PV_LOW: state_nxt.cfg.pv_low_limit = clamp(PWDATA, PCT_MAX);
            OFS_WDOG: state_nxt.cfg.comm_watchdog_period = clamp(PWDATA, WDOG_MAX);
            OFS_OPT_TO: state_nxt.cfg.option_link_timeout = clamp(PWDATA, WDOG_MAX);
            default: state_nxt.cfg = state_r.cfg;
         endcase
      end
   end

   // -------------------------------------------------------------
   // registers
   // -------------------------------------------------------------
   always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= '0;
         state_r.cfg.term_sel[0] <= FN_RUN;
         state_r.cfg.term_sel[1] <= FN_RUN;
         state_r.cfg.analog_monitor_source_select <= AM_SRC_FREQ;
         state_r.cfg.low_load_mode <= LL_MODE_CONST;
         state_r.cfg.low_load_level <= RATED_CURRENT;
         state_r.cfg.overload_level <= RATED_CURRENT;
         state_r.cfg.overload_level_second_motor <= RATED_CURRENT;
         state_r.cfg.accel_arrival_threshold <= ZERO16;
         state_r.cfg.decel_arrival_threshold <= ZERO16;
         state_r.cfg.pid_deviation_threshold <= PID_DEV_DEF;
         state_r.cfg.pv_high_limit <= PV_HIGH_DEF;
         state_r.cfg.pv_low_limit <= ZERO16;
         state_r.cfg.comm_watchdog_period <= ZERO16;
         state_r.cfg.option_link_timeout <= OPT_TIMEOUT_DEFAULT;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign PREADY = 1'b1;
   assign PRDATA = state_r.prdata;
   assign PSLVERR = state_r.pslverr && PSEL && PENABLE;
   assign OUT_TERM = state_r.term;
   assign FLAGS = state_r.flags;
   assign ANALOG_MONITOR = state_r.monitor;

endmodule // drive_status_flag_generator
`default_nettype wire

//--- bench/drive_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module drive_core_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic comm_en,
   input wire logic opt_en,
   output logic comm_act,
   output logic opt_act
);
   logic [1:0] phase_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_r <= 2'h0;
      end else begin
         phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
      end
   end
   // traffic every third cycle, inside any watchdog period of two ticks or more
   assign comm_act = comm_en && (phase_r == 2'h0);
   assign opt_act = opt_en && (phase_r == 2'h1);
endmodule // drive_core_model
`default_nettype wire

//--- bench/drive_status_flag_generator_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module drive_status_flag_generator_asserts
   import drive_flag_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PSLVERR,
   input wire logic [15:0] OUTPUT_FREQ,
   input wire logic [15:0] SET_FREQ,
   input wire logic [15:0] PID_PV,
   input wire logic RUNNING,
   input wire logic ACCELERATING,
   input wire logic DECELERATING,
   input wire logic COMM_ACTIVITY,
   input wire logic OPTION_ACTIVITY,
   input wire logic LOGIC_RESULT,
   input wire flags_type FLAGS
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // $past guards: first edge after reset still sees reset-time inputs
   run_follow_a: assert property ($past(RESET_N) |-> FLAGS.run == $past(RUNNING))
      else $error("run flag not one cycle behind run state");
   logic_follow_a: assert property ($past(RESET_N) |-> FLAGS.logic_out == $past(LOGIC_RESULT))
      else $error("logic output not following combiner");
   const_arrival_a: assert property ($past(RESET_N) |-> FLAGS.const_arrival ==
      $past(RUNNING && !ACCELERATING && !DECELERATING && OUTPUT_FREQ == SET_FREQ))
      else $error("constant speed arrival wrong");
   pv_high_clear_a: assert property ($past(RESET_N) && $past(PID_PV) > PCT_MAX |->
      !FLAGS.pid_second_stage) else $error("second stage set above high limit");
   stop_clear_a: assert property ($past(RESET_N) && $fell(RUNNING) |=>
      !FLAGS.pid_second_stage) else $error("second stage kept after stop");
   stopped_no_low_a: assert property (!RUNNING |=> !FLAGS.low_load)
      else $error("low load flag while stopped");
   net_quiet_a: assert property (COMM_ACTIVITY |=> !FLAGS.network_timeout)
      else $error("network flag despite traffic");
   opt_quiet_a: assert property (OPTION_ACTIVITY |=> !FLAGS.option_link_fault)
      else $error("option fault despite traffic");
   err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error outside access phase");
endmodule // drive_status_flag_generator_asserts
bind drive_status_flag_generator drive_status_flag_generator_asserts u_chk (.CLK(CLK),
   .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PSLVERR(PSLVERR),
   .OUTPUT_FREQ(OUTPUT_FREQ), .SET_FREQ(SET_FREQ), .PID_PV(PID_PV), .RUNNING(RUNNING),
   .ACCELERATING(ACCELERATING), .DECELERATING(DECELERATING), .COMM_ACTIVITY(COMM_ACTIVITY),
   .OPTION_ACTIVITY(OPTION_ACTIVITY), .LOGIC_RESULT(LOGIC_RESULT), .FLAGS(FLAGS));
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
   import drive_flag_pkg::*;
;
   typedef struct packed {
      logic run, acc, dec;
      logic [15:0] fr, st, cu, sp, pv;
      logic lg;
      logic [9:0] ex;
   } row_type;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, er;
   logic run, acc, dec, lg, comm_en, opt_en, comm_act, opt_act;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] fr, st, cu, sp, pv;
   logic [1:0] out_term;
   logic [AM_W-1:0] am;
   flags_type flags;
   int bad_count, samples_checked;
   // -----------------------------------------------
   // expected values
   // -----------------------------------------------
   row_type rows [5] = '{
      '{1'b1, 1'b0, 1'b0, 16'h01f4, 16'h01f4, 16'h0384, 16'h01f4, 16'h01f4, 1'b1, 10'h385},
      '{1'b1, 1'b1, 1'b0, 16'h0190, 16'h01f4, 16'h03e9, 16'h01f4, 16'h01d5, 1'b0, 10'h260},
      '{1'b1, 1'b0, 1'b1, 16'h0258, 16'h01f4, 16'h03e8, 16'h01f4, 16'h01d6, 1'b1, 10'h284},
      '{1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 1'b0, 10'h000},
      '{1'b1, 1'b0, 1'b0, 16'h01f4, 16'h01f4, 16'h03e7, 16'h0000, 16'h03e9, 1'b0, 10'h3a1}};
   logic [31:0] defs [11] = '{32'h00020000, 32'h3e8, 32'h3e8, 32'h3e8, 32'h0, 32'h0,
      32'h1e, 32'h3e8, 32'h0, 32'h0, 32'h64};
   logic [17:0] pid_steps [6] = '{18'h30064, 18'h301f4, 18'h10384, 18'h101f4, 18'h30064,
      18'h00064};
   logic [42:0] mon [4] = '{{1'b1, 16'h0000, 16'h07d0, 10'h3ff},
      {1'b1, 16'h0000, 16'h03e8, 10'h1ff}, {1'b0, 16'h0fa0, 16'h0000, 10'h3ff},
      {1'b0, 16'h07d0, 16'h0000, 10'h1ff}};
   logic [17:0] sel_rows [3] = '{18'h10301, 18'h20409, 18'h10502};
   drive_status_flag_generator #(.TICK_CYCLES(4)) u_drive_status_flag_generator (.CLK(clk),
      .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .OUTPUT_FREQ(fr), .SET_FREQ(st), .MOTOR_CURRENT(cu), .PID_SETPOINT(sp), .PID_PV(pv),
      .RUNNING(run), .ACCELERATING(acc), .DECELERATING(dec), .COMM_ACTIVITY(comm_act),
      .OPTION_ACTIVITY(opt_act), .LOGIC_RESULT(lg), .OUT_TERM(out_term), .FLAGS(flags),
      .ANALOG_MONITOR(am));
   drive_core_model u_drive_core_model (.clk(clk), .reset_n(reset_n), .comm_en(comm_en),
      .opt_en(opt_en), .comm_act(comm_act), .opt_act(opt_act));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // -----------------------------------------------
   // tasks
   // -----------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      stop_test();
   end
   initial begin
      {psel, penable, pwrite, run, acc, dec, lg, reset_n, paddr, pwdata} = '0;
      {fr, st, cu, sp, pv} = '0;
      {comm_en, opt_en} = 2'b11;
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, 8'(i * 4), 32'h0);
         chk(rd, defs[i], "default value");
      end
      apb(1'b0, 8'h34, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped read error");
      apb(1'b1, OFS_STATUS, 32'hff);
      chk({31'h0, er}, 32'h1, "read-only write error");
      foreach (rows[i]) begin
         @(posedge clk);
         {run, acc, dec, fr, st, cu, sp, pv, lg} <= rows[i][93:10];
         settle(2);
         chk({22'h0, flags}, {22'h0, rows[i].ex}, "flag row");
      end
      // terminal codes not reached elsewhere, inputs still from the last row
      foreach (sel_rows[i]) begin
         apb(1'b1, OFS_CTRL, {16'h0000, sel_rows[i][15:0]});
         settle(2);
         chk({30'h0, out_term}, {30'h0, sel_rows[i][17:16]},
            "terminal code");
      end
      apb(1'b1, OFS_LL_LEVEL, 32'hffff);
      apb(1'b0, OFS_LL_LEVEL, 32'h0);
      chk(rd, 32'h7d0, "low level clamp");
      apb(1'b1, OFS_LL_LEVEL, 32'h3e8);
      // ramp thresholds pull arrival away from the set frequency
      apb(1'b1, OFS_ACC_THR, 32'h1c2);
      apb(1'b1, OFS_DEC_THR, 32'h190);
      @(posedge clk);
      {acc, fr} <= {1'b1, 16'h01c2};
      settle(2);
      chk({31'h0, flags.over_arrival}, 32'h1, "accel arrival");
      @(posedge clk);
      {acc, dec} <= 2'b01;
      settle(2);
      chk({31'h0, flags.over_arrival}, 32'h1, "decel arrival");
      // all-speed mode with second motor level on code 43
      apb(1'b1, OFS_OL_LEVEL2, 32'h1f4);
      apb(1'b1, OFS_CTRL, 32'h0004002b);
      @(posedge clk);
      {run, acc, dec, cu} <= {3'b110, 16'h0258};
      settle(2);
      chk({28'h0, flags.overload_warning, flags.low_load, out_term[0], flags.run}, 32'hf,
         "low load accel");
      @(posedge clk);
      cu <= 16'h044c;
      settle(2);
      chk({28'h0, flags.overload_warning, flags.low_load, out_term[0], flags.run}, 32'h9,
         "overload high");
      apb(1'b1, OFS_PV_LOW, 32'hc8);
      apb(1'b1, OFS_PV_HIGH, 32'h320);
      apb(1'b1, OFS_CTRL, 32'h00020007);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         {run, pv} <= pid_steps[i][16:0];
         settle(2);
         chk({30'h0, flags.pid_second_stage, out_term[0]}, {30'h0, {2{pid_steps[i][17]}}},
            "second stage");
      end
      apb(1'b1, OFS_WDOG, 32'h2);
      apb(1'b1, OFS_OPT_TO, 32'h2);
      apb(1'b1, OFS_CTRL, 32'h0002080a);
      settle(40);
      chk({30'h0, out_term}, 32'h0, "timers with traffic");
      @(posedge clk);
      {comm_en, opt_en} <= 2'b00;
      settle(20);
      chk({30'h0, out_term}, 32'h3, "timers expired");
      @(posedge clk);
      {comm_en, opt_en} <= 2'b11;
      settle(5);
      chk({30'h0, out_term}, 32'h0, "timers restarted");
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_CTRL, {15'h0, mon[i][42], 16'h0});
         @(posedge clk);
         {fr, cu} <= mon[i][41:10];
         settle(2);
         chk({22'h0, am}, {22'h0, mon[i][9:0]}, "monitor");
      end
      // second reset in mid-run
      @(posedge clk);
      reset_n <= 1'b0;
      settle(2);
      chk({20'h0, out_term, flags}, 32'h0, "outputs in reset");
      @(posedge clk);
      reset_n <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h00020000, "control after reset");
      stop_test();
   end
endmodule // tb
`default_nettype wire
